// ### hw/gain_ramp.sv
// Steps an applied output-stage gain toward its programmed target
`timescale 1ns/1ps
`default_nettype none
module gain_ramp
  import spk_bias_pkg::*;
#(
  parameter int STEP_CYC = GAIN_STEP_CYC
) (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // Programmed target
  input  wire logic [1:0] target,
  // Applied gain and completion flag
  output logic      [1:0] applied,
  output logic            done
);

  initial begin
    if (STEP_CYC < 1) $error("STEP_CYC must be at least 1");
  end

  logic [15:0] cnt_reg;
  logic [15:0] cnt_next;
  logic [1:0]  gain_reg;
  logic [1:0]  gain_next;
  wire         at_target = (gain_reg == target);
  wire         tick      = (cnt_reg == 16'(STEP_CYC - 1));

  // Move one code per step so the stage never jumps abruptly
  assign cnt_next  = (at_target || tick) ? 16'h0000 : cnt_reg + 16'h0001;
  assign gain_next = (!at_target && tick)
                     ? ((gain_reg < target) ? gain_reg + 2'h1
                                            : gain_reg - 2'h1)
                     : gain_reg;

  // Step state; reset matches the register reset so done starts high
  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_reg  <= 16'h0000;
      gain_reg <= 2'h0;
    end else begin
      cnt_reg  <= cnt_next;
      gain_reg <= gain_next;
    end
  end

  assign applied = gain_reg;
  assign done    = at_target;

endmodule : gain_ramp
`default_nettype wire

// ### hw/short_debounce.sv
// Debounces headset short detection over eight ticks of a scaled clock
`timescale 1ns/1ps
`default_nettype none
module short_debounce
  import spk_bias_pkg::*;
#(
  parameter int OSC_DIV = 25
) (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // Timebase choice and source ticks
  input  wire logic       use_osc,
  input  wire logic       timer_tick,
  // Debounce code and raw detector
  input  wire logic [2:0] code,
  input  wire logic       short_raw,
  // Filtered result
  output logic            short_out
);

  initial begin
    if (OSC_DIV < 1) $error("OSC_DIV must be at least 1");
  end

  logic [7:0]  osc_cnt_reg;
  logic [8:0]  pre_reg;
  logic [3:0]  run_reg;
  logic        out_reg;
  wire         osc_tick   = (osc_cnt_reg == 8'(OSC_DIV - 1));
  wire         base_tick  = use_osc ? osc_tick : timer_tick;
  // Code n gives a tick every 2^(n-1) base ticks; code 0 bypasses
  wire  [8:0]  pre_limit  = (code == 3'h0) ? 9'h000
                            : 9'((9'h001 << (code - 3'h1)) - 9'h001);
  wire         deb_tick   = base_tick && (pre_reg == pre_limit);
  wire         agree      = (short_raw == out_reg);

  // Divider and eight-tick agreement window
  always_ff @(posedge clk) begin
    if (rst) begin
      osc_cnt_reg <= 8'h00;
      pre_reg     <= 9'h000;
      run_reg     <= 4'h0;
      out_reg     <= 1'b0;
    end else begin
      osc_cnt_reg <= osc_tick ? 8'h00 : osc_cnt_reg + 8'h01;
      // Prescaler restarts while idle so the first interval is full length
      if (agree || code == 3'h0)
        pre_reg <= 9'h000;
      else if (base_tick)
        pre_reg <= (pre_reg == pre_limit) ? 9'h000 : pre_reg + 9'h001;
      if (code == 3'h0) begin
        out_reg <= short_raw;
        run_reg <= 4'h0;
      end else if (agree) begin
        run_reg <= 4'h0;
      end else if (deb_tick) begin
        if (run_reg == 4'(DEB_TICKS - 1)) begin
          out_reg <= short_raw;
          run_reg <= 4'h0;
        end else begin
          run_reg <= run_reg + 4'h1;
        end
      end
    end
  end

  assign short_out = out_reg;

endmodule : short_debounce
`default_nettype wire

// ### hw/spk_bias_pkg.sv
// Register map, field layout and timing constants for the speaker/bias bank
package spk_bias_pkg;

  // Page selection and register addresses on the page
  localparam logic [7:0] PAGE_SEL_ADDR      = 8'h00;
  localparam logic [7:0] BANK_PAGE          = 8'h01;
  localparam logic [7:0] TIMER_PAGE         = 8'h03;
  localparam logic [7:0] TIMER_DIV_ADDR     = 8'h10;
  localparam logic [7:0] LEFT_SPK_ADDR      = 8'h2a;
  localparam logic [7:0] RIGHT_SPK_ADDR     = 8'h2b;
  localparam logic [7:0] PHONES_CTRL_ADDR   = 8'h2c;
  localparam logic [7:0] RESERVED_GAP_ADDR  = 8'h2d;
  localparam logic [7:0] MIC_BIAS_ADDR      = 8'h2e;

  // Writable masks; reserved bits and status bits never store
  localparam logic [7:0] SPK_WMASK          = 8'h1c;
  localparam logic [7:0] PHONES_WMASK       = 8'hfe;
  localparam logic [7:0] MIC_WMASK          = 8'h8b;

  // Reset values
  localparam logic [7:0] SPK_RESET          = 8'h00;
  localparam logic [7:0] PHONES_RESET       = 8'h00;
  localparam logic [7:0] MIC_RESET          = 8'h00;
  localparam logic [7:0] PAGE_RESET         = 8'h00;
  localparam logic [7:0] TIMER_DIV_RESET    = 8'h01;

  // Field positions
  localparam int SPK_GAIN_LSB   = 3;
  localparam int SPK_MUTE_BIT   = 2;
  localparam int SPK_DONE_BIT   = 0;
  localparam int DEB_LSB        = 5;
  localparam int DAC_PERF_LSB   = 3;
  localparam int LEFT_LO_BIT    = 2;
  localparam int RIGHT_LO_BIT   = 1;
  localparam int SWPD_BIT       = 7;
  localparam int HS_OVR_BIT     = 3;
  localparam int BIAS_LSB       = 0;
  localparam int TIMER_DIV_W    = 7;

  // Gain ramp: one output-stage step per interval
  localparam int GAIN_STEP_NS    = 100;
  localparam int CLK_PERIOD_NS   = 5;
  localparam int GAIN_STEP_CYC   = (GAIN_STEP_NS + CLK_PERIOD_NS - 1)
                                   / CLK_PERIOD_NS;

  // Debounce: eight ticks per interval, tick doubles per code
  localparam int DEB_TICKS       = 8;

  // Field codes
  typedef enum logic [1:0] {
    BIAS_OFF  = 2'b00,
    BIAS_2V0  = 2'b01,
    BIAS_2V5  = 2'b10,
    BIAS_RAIL = 2'b11
  } bias_level_t;

  localparam logic [1:0] DAC_PERF_RSVD = 2'b10;

endpackage : spk_bias_pkg

// ### hw/spk_bias_regs.sv
// Speaker, phones and mic-bias control bank on page 1 of the control space
//
// Functional notes
// - Left gain codes give 6/12/18/24 dB
// - Right gain codes give 6/12/18/24 dB
// - Left mute bit 0 mutes, 1 plays
// - Right mute bit 0 mutes, 1 plays
// - Left done bit high when gain applied
// - Right done bit high when gain applied
// - Timer debounce 0 to 512 us
// - Oscillator debounce scales with oscillator rate
// - Debounce lasts eight debounce clock periods
// - DAC performance 00 default, 01/11 increased
// - Mode bits select phones or line-out
// - Top mic bit enables software power-down
// - Override bit powers bias without headset
// - Bias codes off, 2 V, 2.5 V, rail
// - Reset: muted, lowest gain, phones, bias off
// - Timer clock from page-3 divider register
`timescale 1ns/1ps
`default_nettype none
module spk_bias_regs
  import spk_bias_pkg::*;
#(
  parameter int STEP_CYC = GAIN_STEP_CYC,
  parameter int OSC_DIV  = 25,
  parameter int MCLK_W   = TIMER_DIV_W
) (
  // Clock and reset
  input  wire logic       SYS_CLK,
  input  wire logic       RESET,
  // Register port
  input  wire logic       WR_EN,
  input  wire logic       RD_EN,
  input  wire logic [7:0] ADDR,
  input  wire logic [7:0] WR_DATA,
  output logic      [7:0] RD_DATA,
  // Timer source and headset sensing
  input  wire logic       MCLK_TICK,
  input  wire logic       USE_OSC,
  input  wire logic       HEADSET_DETECT_EN,
  input  wire logic       HEADSET_PRESENT,
  input  wire logic       SHORT_RAW,
  // Left speaker controls
  output logic      [1:0] LEFT_SPEAKER_AMP_GAIN,
  output logic            LEFT_SPEAKER_AMP_EN,
  // Right speaker controls
  output logic      [1:0] RIGHT_SPEAKER_AMP_GAIN,
  output logic            RIGHT_SPEAKER_AMP_EN,
  // Phones and DAC controls
  output logic            LEFT_PHONES_AMP_LINEOUT,
  output logic            RIGHT_PHONES_AMP_LINEOUT,
  output logic            DAC_PERF_BOOST,
  output logic            SHORT_DETECTED,
  // Mic supply and power-down
  output logic      [1:0] MIC_SUPPLY_OUTPUT_LEVEL,
  output logic            SOFT_POWER_DOWN
);

  initial begin
    if (STEP_CYC < 1) $error("STEP_CYC must be at least 1");
    if (OSC_DIV < 1 || OSC_DIV > 255) $error("OSC_DIV out of range");
    if (MCLK_W < 1 || MCLK_W > 8) $error("MCLK_W out of range");
  end

  // Stored registers
  logic [7:0] page_reg;
  logic [7:0] left_spk_reg;
  logic [7:0] right_spk_reg;
  logic [7:0] phones_reg;
  logic [7:0] mic_reg;
  logic [7:0] timer_div_reg;
  logic [7:0] mclk_cnt_reg;
  logic       mclk_tick_reg;
  logic [7:0] rd_data_reg;
  logic [1:0] left_gain_reg;
  logic       left_en_reg;
  logic [1:0] right_gain_reg;
  logic       right_en_reg;
  logic       left_lo_reg;
  logic       right_lo_reg;
  logic       dac_boost_reg;
  logic       short_reg;
  logic [1:0] bias_reg;
  logic       swpd_reg;

  // Address decode; only the selected page reaches its registers
  wire on_bank   = (page_reg == BANK_PAGE);
  wire on_timer  = (page_reg == TIMER_PAGE);
  wire sel_page  = (ADDR == PAGE_SEL_ADDR);
  wire sel_left  = on_bank && (ADDR == LEFT_SPK_ADDR);
  wire sel_right = on_bank && (ADDR == RIGHT_SPK_ADDR);
  wire sel_phone = on_bank && (ADDR == PHONES_CTRL_ADDR);
  wire sel_mic   = on_bank && (ADDR == MIC_BIAS_ADDR);
  wire sel_tdiv  = on_timer && (ADDR == TIMER_DIV_ADDR);

  // Bank writes keep only defined bits; reserved gap is simply not stored
  wire [7:0] left_spk_next  = WR_DATA & SPK_WMASK;
  wire [7:0] right_spk_next = WR_DATA & SPK_WMASK;
  wire [7:0] phones_next    = WR_DATA & PHONES_WMASK;
  wire [7:0] mic_next       = WR_DATA & MIC_WMASK;

  // Reserved DAC code is refused so the mode never goes undefined
  wire [1:0] dac_code     = WR_DATA[DAC_PERF_LSB +: 2];
  wire       dac_code_bad = (dac_code == DAC_PERF_RSVD);

  // Gain ramps report the applied gain and completion
  wire [1:0] left_applied;
  wire [1:0] right_applied;
  wire       left_done;
  wire       right_done;

  gain_ramp #(
    .STEP_CYC (STEP_CYC)
  ) u_left_ramp (
    .clk     (SYS_CLK),
    .rst     (RESET),
    .target  (left_spk_reg[SPK_GAIN_LSB +: 2]),
    .applied (left_applied),
    .done    (left_done)
  );

  gain_ramp #(
    .STEP_CYC (STEP_CYC)
  ) u_right_ramp (
    .clk     (SYS_CLK),
    .rst     (RESET),
    .target  (right_spk_reg[SPK_GAIN_LSB +: 2]),
    .applied (right_applied),
    .done    (right_done)
  );

  // Timer tick from the divider register, one pulse per count
  wire [7:0] mclk_limit = timer_div_reg & 8'((1 << MCLK_W) - 1);
  wire       mclk_wrap  = MCLK_TICK &&
                          (mclk_cnt_reg + 8'h01 >= mclk_limit);

  wire deb_short;

  short_debounce #(
    .OSC_DIV (OSC_DIV)
  ) u_debounce (
    .clk        (SYS_CLK),
    .rst        (RESET),
    .use_osc    (USE_OSC),
    .timer_tick (mclk_tick_reg),
    .code       (phones_reg[DEB_LSB +: 3]),
    .short_raw  (SHORT_RAW),
    .short_out  (deb_short)
  );

  // Read mux; live status bits merge in, reads have no side effect
  wire [7:0] left_rd  = left_spk_reg
                        | {7'h00, left_done};
  wire [7:0] right_rd = right_spk_reg
                        | {7'h00, right_done};
  wire [7:0] rd_mux   = sel_page  ? page_reg      :
                        sel_left  ? left_rd       :
                        sel_right ? right_rd      :
                        sel_phone ? phones_reg    :
                        sel_mic   ? mic_reg       :
                        sel_tdiv  ? timer_div_reg : 8'h00;

  // Bias gated by headset presence unless overridden
  wire bias_allowed = mic_reg[HS_OVR_BIT] || !HEADSET_DETECT_EN
                      || HEADSET_PRESENT;
  wire [1:0] bias_code = bias_allowed ? mic_reg[BIAS_LSB +: 2]
                                      : BIAS_OFF;

  // Register writes
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      page_reg      <= PAGE_RESET;
      left_spk_reg  <= SPK_RESET;
      right_spk_reg <= SPK_RESET;
      phones_reg    <= PHONES_RESET;
      mic_reg       <= MIC_RESET;
      timer_div_reg <= TIMER_DIV_RESET;
    end else if (WR_EN) begin
      if (sel_page)
        page_reg <= WR_DATA;
      if (sel_left)
        left_spk_reg <= left_spk_next;
      if (sel_right)
        right_spk_reg <= right_spk_next;
      if (sel_phone && !dac_code_bad)
        phones_reg <= phones_next;
      if (sel_mic)
        mic_reg <= mic_next;
      if (sel_tdiv)
        timer_div_reg <= WR_DATA;
    end
  end

  // Timer divider counter
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      mclk_cnt_reg  <= 8'h00;
      mclk_tick_reg <= 1'b0;
    end else begin
      mclk_tick_reg <= mclk_wrap;
      if (mclk_wrap)
        mclk_cnt_reg <= 8'h00;
      else if (MCLK_TICK)
        mclk_cnt_reg <= mclk_cnt_reg + 8'h01;
    end
  end

  // Registered read data, held between reads
  always_ff @(posedge SYS_CLK) begin
    if (RESET)
      rd_data_reg <= 8'h00;
    else if (RD_EN)
      rd_data_reg <= rd_mux;
  end

  // Speaker outputs follow the applied gain, not the target
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      left_gain_reg  <= 2'h0;
      left_en_reg    <= 1'b0;
      right_gain_reg <= 2'h0;
      right_en_reg   <= 1'b0;
    end else begin
      left_gain_reg  <= left_applied;
      left_en_reg    <= left_spk_reg[SPK_MUTE_BIT];
      right_gain_reg <= right_applied;
      right_en_reg   <= right_spk_reg[SPK_MUTE_BIT];
    end
  end

  // Phones, DAC, bias and power-down outputs
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      left_lo_reg   <= 1'b0;
      right_lo_reg  <= 1'b0;
      dac_boost_reg <= 1'b0;
      short_reg     <= 1'b0;
      bias_reg      <= BIAS_OFF;
      swpd_reg      <= 1'b0;
    end else begin
      left_lo_reg   <= phones_reg[LEFT_LO_BIT];
      right_lo_reg  <= phones_reg[RIGHT_LO_BIT];
      dac_boost_reg <= phones_reg[DAC_PERF_LSB];
      short_reg     <= deb_short;
      bias_reg      <= bias_code;
      swpd_reg      <= mic_reg[SWPD_BIT];
    end
  end

  assign RD_DATA                  = rd_data_reg;
  assign LEFT_SPEAKER_AMP_GAIN    = left_gain_reg;
  assign LEFT_SPEAKER_AMP_EN      = left_en_reg;
  assign RIGHT_SPEAKER_AMP_GAIN   = right_gain_reg;
  assign RIGHT_SPEAKER_AMP_EN     = right_en_reg;
  assign LEFT_PHONES_AMP_LINEOUT  = left_lo_reg;
  assign RIGHT_PHONES_AMP_LINEOUT = right_lo_reg;
  assign DAC_PERF_BOOST           = dac_boost_reg;
  assign SHORT_DETECTED           = short_reg;
  assign MIC_SUPPLY_OUTPUT_LEVEL  = bias_reg;
  assign SOFT_POWER_DOWN          = swpd_reg;

endmodule : spk_bias_regs
`default_nettype wire

// ### tb/spk_bias_regs_sva.sv
// Port checker for the speaker, phones and mic-bias bank
`timescale 1ns/1ps
`default_nettype none
module spk_bias_regs_sva
  import spk_bias_pkg::*;
#(
  parameter int STEP_CYC = GAIN_STEP_CYC,
  parameter int OSC_DIV  = 25,
  parameter int MCLK_W   = TIMER_DIV_W
) (
  // Clock, reset and register port
  input wire logic       SYS_CLK, RESET, WR_EN, RD_EN,
  input wire logic [7:0] ADDR, WR_DATA, RD_DATA,
  // Headset sensing
  input wire logic       HEADSET_DETECT_EN, HEADSET_PRESENT,
  // Control outputs
  input wire logic [1:0] LEFT_SPEAKER_AMP_GAIN, RIGHT_SPEAKER_AMP_GAIN,
  input wire logic [1:0] MIC_SUPPLY_OUTPUT_LEVEL,
  input wire logic       LEFT_SPEAKER_AMP_EN, RIGHT_SPEAKER_AMP_EN,
  input wire logic       LEFT_PHONES_AMP_LINEOUT, RIGHT_PHONES_AMP_LINEOUT,
  input wire logic       DAC_PERF_BOOST, SOFT_POWER_DOWN
);
  logic [7:0] pg_reg, ph_reg, mb_reg;
  logic       le_reg, re_reg;
  wire logic  on1 = pg_reg == BANK_PAGE;

  // Shadow of the stored fields; reserved DAC code drops the whole write
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      pg_reg <= PAGE_RESET;
      ph_reg <= PHONES_RESET;
      mb_reg <= MIC_RESET;
      le_reg <= 1'b0;
      re_reg <= 1'b0;
    end else if (WR_EN) begin
      if (ADDR == PAGE_SEL_ADDR) pg_reg <= WR_DATA;
      if (on1 && ADDR == LEFT_SPK_ADDR) le_reg <= WR_DATA[SPK_MUTE_BIT];
      if (on1 && ADDR == RIGHT_SPK_ADDR) re_reg <= WR_DATA[SPK_MUTE_BIT];
      if (on1 && ADDR == MIC_BIAS_ADDR) mb_reg <= WR_DATA;
      if (on1 && ADDR == PHONES_CTRL_ADDR && WR_DATA[4:3] != DAC_PERF_RSVD)
        ph_reg <= WR_DATA;
    end
  end

  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (RESET);

  // Settled: no write and steady headset inputs long enough to propagate
  sequence s_quiet;
    (!WR_EN && $stable(HEADSET_DETECT_EN) && $stable(HEADSET_PRESENT))[*3];
  endsequence
  sequence s_rd(logic [7:0] a);
    RD_EN && on1 && ADDR == a;
  endsequence

  property p_rst;
    disable iff (1'b0) RESET |=> !LEFT_SPEAKER_AMP_EN && !RIGHT_SPEAKER_AMP_EN
      && LEFT_SPEAKER_AMP_GAIN == 2'h0 && RIGHT_SPEAKER_AMP_GAIN == 2'h0
      && !LEFT_PHONES_AMP_LINEOUT && !RIGHT_PHONES_AMP_LINEOUT
      && MIC_SUPPLY_OUTPUT_LEVEL == 2'h0;
  endproperty
  a_rst: assert property (p_rst) else $error("reset state wrong");
  property p_lstep;
    $changed(LEFT_SPEAKER_AMP_GAIN) |-> (LEFT_SPEAKER_AMP_GAIN
      - $past(LEFT_SPEAKER_AMP_GAIN)) inside {2'h1, 2'h3};
  endproperty
  a_lstep: assert property (p_lstep) else $error("left gain jump");
  property p_rstep;
    $changed(RIGHT_SPEAKER_AMP_GAIN) |-> (RIGHT_SPEAKER_AMP_GAIN
      - $past(RIGHT_SPEAKER_AMP_GAIN)) inside {2'h1, 2'h3};
  endproperty
  a_rstep: assert property (p_rstep) else $error("right gain jump");
  property p_lmute;
    s_quiet |-> LEFT_SPEAKER_AMP_EN == le_reg;
  endproperty
  a_lmute: assert property (p_lmute) else $error("left mute wrong");
  property p_rmute;
    s_quiet |-> RIGHT_SPEAKER_AMP_EN == re_reg;
  endproperty
  a_rmute: assert property (p_rmute) else $error("right mute wrong");
  property p_mode;
    s_quiet |-> {LEFT_PHONES_AMP_LINEOUT, RIGHT_PHONES_AMP_LINEOUT}
      == ph_reg[2:1];
  endproperty
  a_mode: assert property (p_mode) else $error("phones mode wrong");
  property p_dac;
    s_quiet |-> DAC_PERF_BOOST == ph_reg[DAC_PERF_LSB];
  endproperty
  a_dac: assert property (p_dac) else $error("dac mode wrong");
  property p_swpd;
    s_quiet |-> SOFT_POWER_DOWN == mb_reg[SWPD_BIT];
  endproperty
  a_swpd: assert property (p_swpd) else $error("power-down wrong");
  property p_bias;
    s_quiet |-> MIC_SUPPLY_OUTPUT_LEVEL == ((mb_reg[HS_OVR_BIT]
      || !HEADSET_DETECT_EN || HEADSET_PRESENT) ? mb_reg[1:0] : 2'h0);
  endproperty
  a_bias: assert property (p_bias) else $error("bias wrong");
  property p_gap;
    s_rd(RESERVED_GAP_ADDR) |=> RD_DATA == 8'h00;
  endproperty
  a_gap: assert property (p_gap) else $error("gap read not zero");
  property p_rsv;
    s_rd(LEFT_SPK_ADDR) |=> RD_DATA[7:5] == 3'h0 && !RD_DATA[1];
  endproperty
  a_rsv: assert property (p_rsv) else $error("reserved bits set");
endmodule // spk_bias_regs_sva

bind spk_bias_regs spk_bias_regs_sva #(.STEP_CYC(STEP_CYC),
  .OSC_DIV(OSC_DIV), .MCLK_W(MCLK_W)) u_sva (.*);
`default_nettype wire

// ### tb/spk_bias_regs_tb.sv
// Self-checking bench for the speaker, phones and mic-bias bank
`timescale 1ns/1ps
`default_nettype none
module spk_bias_regs_tb;
  import spk_bias_pkg::*;
  localparam int OSCD = 4;
  logic       clk = 0, rst = 1, we = 0, re = 0, tick = 0, osc = 0;
  logic       det = 0, pres = 0, sraw = 0, len, ren, llo, rlo, dac, sdet, spd;
  logic [7:0] addr = '0, wd = '0, rd, sl, sr, sp, sm;
  logic [1:0] lg, rg, mic;
  int         n_fail = 0, num_checks = 0, tc = 0;
  wire logic [11:0] outs = {lg, len, rg, ren, llo, rlo, dac, mic, spd};
  `define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin \
    n_fail++; $display("BAD %0t got %h want %h", $time, g, e); end end

  spk_bias_regs #(.STEP_CYC(2), .OSC_DIV(OSCD)) uut (
    .SYS_CLK(clk), .RESET(rst), .WR_EN(we), .RD_EN(re), .ADDR(addr),
    .WR_DATA(wd), .RD_DATA(rd), .MCLK_TICK(tick), .USE_OSC(osc),
    .HEADSET_DETECT_EN(det), .HEADSET_PRESENT(pres), .SHORT_RAW(sraw),
    .LEFT_SPEAKER_AMP_GAIN(lg), .LEFT_SPEAKER_AMP_EN(len),
    .RIGHT_SPEAKER_AMP_GAIN(rg), .RIGHT_SPEAKER_AMP_EN(ren),
    .LEFT_PHONES_AMP_LINEOUT(llo), .RIGHT_PHONES_AMP_LINEOUT(rlo),
    .DAC_PERF_BOOST(dac), .SHORT_DETECTED(sdet),
    .MIC_SUPPLY_OUTPUT_LEVEL(mic), .SOFT_POWER_DOWN(spd));

  // Clock and a master-clock tick every fourth cycle
  always #2.5 clk = ~clk;
  always @(posedge clk) begin
    #1;
    tc = tc + 1;
    tick = (tc % 4 == 0);
  end

  // Rows: address, data, headset detect enable, headset present
  logic [17:0] rows [18] = '{{8'h2a, 8'h1c, 2'b00}, {8'h2a, 8'h08, 2'b00},
    {8'h2a, 8'h10, 2'b00}, {8'h2b, 8'h04, 2'b00}, {8'h2b, 8'h0c, 2'b00},
    {8'h2b, 8'h1c, 2'b00}, {8'h2b, 8'h10, 2'b00}, {8'h2c, 8'h08, 2'b00},
    {8'h2c, 8'h18, 2'b00}, {8'h2c, 8'h04, 2'b00}, {8'h2c, 8'h02, 2'b00},
    {8'h2c, 8'he6, 2'b00}, {8'h2e, 8'h80, 2'b00}, {8'h2e, 8'h01, 2'b10},
    {8'h2e, 8'h01, 2'b11}, {8'h2e, 8'h02, 2'b00}, {8'h2e, 8'h0b, 2'b10},
    {8'h2e, 8'h03, 2'b10}};
  // Debounce rows: ticks expected, code, divider, oscillator timebase
  int         dn [6] = '{8, 16, 512, 8, 8, 0};
  int         dv [6] = '{1, 1, 1, 2, 1, 1};
  logic [2:0] dcd [6] = '{3'h1, 3'h2, 3'h7, 3'h1, 3'h1, 3'h0};
  logic       dos [6] = '{0, 0, 0, 0, 1, 0};
  logic [7:0] spk [2] = '{LEFT_SPK_ADDR, RIGHT_SPK_ADDR};
  logic [7:0] rsv [4] = '{8'h2a, 8'h2b, 8'h2c, 8'h2e};

  function automatic logic [11:0] exp_out();
    return {sl[4:3], sl[2], sr[4:3], sr[2], sp[2], sp[1], sp[3],
      (sm[3] || !det || pres) ? sm[1:0] : 2'h0, sm[7]};
  endfunction

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, d);
    cyc(1);
    we = 1;
    addr = a;
    wd = d;
    cyc(1);
    we = 0;
  endtask
  task automatic rd_chk(input logic [7:0] a, m, e);
    cyc(1);
    re = 1;
    addr = a;
    cyc(1);
    re = 0;
    `CHK(rd & m, e)
  endtask
  // Reset, then every page-1 bank register reads back cleared in bits 7:1
  task automatic chk_rst();
    rst = 1;
    cyc(6);
    rst = 0;
    {sl, sr, sp, sm} = '0;
    `CHK(outs, 12'h000)
    wr(PAGE_SEL_ADDR, BANK_PAGE);
    foreach (rsv[i]) rd_chk(rsv[i], 8'hfe, 8'h00);
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Watchdog well beyond the expected run of some 5000 cycles
  initial begin
    #100000;
    n_fail++;
    close_out();
  end

  initial begin
    logic [7:0] a, d;
    int p;
    chk_rst();
    foreach (rows[i]) begin
      {a, d, det, pres} = rows[i];
      wr(a, d);
      case (a)
        8'h2a: sl = d;
        8'h2b: sr = d;
        8'h2c: sp = d;
        default: sm = d;
      endcase
      cyc(16);
      rd_chk(a, 8'hff, d | 8'(a inside {8'h2a, 8'h2b}));
      `CHK(outs, exp_out())
    end
    // Done bit low while ramping, write to it ignored
    foreach (spk[i]) begin
      wr(spk[i], 8'h04);
      cyc(16);
      wr(spk[i], 8'h1d);
      rd_chk(spk[i], 8'hff, 8'h1c);
      cyc(16);
      rd_chk(spk[i], 8'hff, 8'h1d);
      rd_chk(spk[i], 8'hff, 8'h1d);
    end
    wr(PHONES_CTRL_ADDR, 8'h10);
    rd_chk(PHONES_CTRL_ADDR, 8'hff, sp);
    // Software never writes the gap; it must still read back as zero
    rd_chk(RESERVED_GAP_ADDR, 8'hff, 8'h00);
    rd_chk(8'h40, 8'hff, 8'h00);
    // Bank hidden off page 1
    wr(PAGE_SEL_ADDR, 8'h00);
    rd_chk(LEFT_SPK_ADDR, 8'hff, 8'h00);
    wr(LEFT_SPK_ADDR, 8'h00);
    wr(PAGE_SEL_ADDR, BANK_PAGE);
    rd_chk(LEFT_SPK_ADDR, 8'hff, 8'h1d);
    // Debounce length per code, divider and timebase
    foreach (dn[i]) begin
      wr(PAGE_SEL_ADDR, TIMER_PAGE);
      wr(TIMER_DIV_ADDR, 8'(dv[i]));
      wr(PAGE_SEL_ADDR, BANK_PAGE);
      wr(PHONES_CTRL_ADDR, {dcd[i], 5'h00});
      osc = dos[i];
      p = 4 * dv[i];
      wait (tick);
      cyc(1);
      sraw = 1;
      if (dn[i] > 0) begin
        cyc((dn[i] - 1) * p);
        `CHK(sdet, 1'b0)
      end
      cyc(2 * p);
      `CHK(sdet, 1'b1)
      sraw = 0;
      cyc((dn[i] + 2) * p);
      `CHK(sdet, 1'b0)
    end
    osc = 0;
    chk_rst();
    close_out();
  end
endmodule // spk_bias_regs_tb
`default_nettype wire
